// ===== hw/supervisor_params.svh
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH

// reset timeout and watchdog timeout, in time-base ticks
`define RST_TIMEOUT_TICKS   16'h0140
`define WD_TIMEOUT_TICKS    16'h0640
// time-base divider: one tick every this many clock cycles
`define TICK_DIV_CYCLES     16'h0028
// switchover ratio 1.01 as 101/100
`define RATIO_NUM           8'h65
`define RATIO_DEN           8'h64
`define VOLT_W              12

`endif

// ===== hw/supervisor_pkg.sv
package supervisor_pkg;
    typedef enum logic [2:0]
    {
        RST_ON   = 3'b001,
        RST_HOLD = 3'b010,
        RST_OFF  = 3'b100
    } rst_state_t;
endpackage : supervisor_pkg

// ===== hw/tick_counter.sv
`timescale 1ns/1ps
// counter that counts ticks while enabled, restarts on clr, flags reaching LIMIT
module tick_counter #(
    parameter int W = 16
) (
    input  wire logic         clk_i,    // clock
    input  wire logic         arst_n_i, // async reset
    input  wire logic         clr_i,    // restart count
    input  wire logic         tick_i,   // count enable tick
    input  wire logic [W-1:0] limit_i,  // terminal count
    output logic              done_o    // count reached limit
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    wire          at_limit = (cnt_r >= limit_i);

    assign cnt_nxt = clr_i ? '0 : ((tick_i && !at_limit) ? cnt_r + 1'b1 : cnt_r);
    assign done_o  = at_limit && !clr_i;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end
endmodule : tick_counter

// ===== hw/supervisor_reset_watchdog.sv
// How it works
// (R01) reset low while supply low or manual low
// (R02) hold reset one timeout after sources clear
// (R03) watchdog expiry gives one reset-timeout pulse
// (R04) watchdog runout also drives reset low
// (R05) watchdog restarts on any edge or reset
// (R06) undriven watchdog input disables watchdog
// (R07) undriven manual reset reads as deasserted
// (R08) battery-on flag high in backup mode
// (R09) power-fail output with hysteresis
// (R10) output to battery: reset and battery higher
// (R11) output to supply otherwise
// (R12) in reset, leave backup only above 1.01 times battery
// (R13) timeouts are tick-count parameters
`timescale 1ns/1ps
`include "supervisor_params.svh"
module supervisor_reset_watchdog #(
    parameter int CW          = 16,
    parameter int RST_TICKS   = `RST_TIMEOUT_TICKS, // [R13]
    parameter int WD_TICKS    = `WD_TIMEOUT_TICKS,  // [R13]
    parameter int DIV_CYCLES  = `TICK_DIV_CYCLES,
    parameter int VW          = `VOLT_W
) (
    input  wire logic          SYS_CLK_I,            // 40 MHz clock
    input  wire logic          ARST_N_I,             // async reset, active low
    input  wire logic          SUPPLY_LOW_I,         // supply below reset threshold
    input  wire logic          MANUAL_RESET_N_I,     // manual reset, active low
    input  wire logic          MANUAL_RESET_OE_I,    // manual reset pin is driven
    input  wire logic          WATCHDOG_KICK_IN_I,   // watchdog input level
    input  wire logic          WATCHDOG_KICK_OE_I,   // watchdog input is driven
    input  wire logic          PF_BELOW_I,           // sense below threshold
    input  wire logic          PF_ABOVE_HYS_I,       // sense above threshold+hysteresis
    input  wire logic [VW-1:0] SUPPLY_LEVEL_I,       // main supply level code
    input  wire logic [VW-1:0] BACKUP_CELL_INPUT_I,  // battery level code
    output logic               RESET_N_O,            // reset out, active low
    output logic               BACKUP_ACTIVE_FLAG_O, // battery-backup mode
    output logic               POWER_FAIL_OUT_N_O,   // power-fail out, active low
    output logic               OUT_FROM_BACKUP_CELL_INPUT_O       // switched output on battery
);
    // counts must fit the counter width, and the shift below must stay inside an int
    if (CW < 2 || CW > 30 || VW < 1 ||
        RST_TICKS < 1 || WD_TICKS < 1 || DIV_CYCLES < 1 ||
        RST_TICKS >= (1 << CW) || WD_TICKS >= (1 << CW) || DIV_CYCLES >= (1 << CW))
    begin : g_bad_timing
        $error("supervisor: timing parameter out of range");
    end

    // free-running time base
    logic [CW-1:0] div_r;
    wire           tick = (div_r == CW'(DIV_CYCLES - 1));
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            div_r <= '0;
        else
            div_r <= tick ? '0 : div_r + 1'b1;
    end

    // a floating pin is pulled up, so only a driven low counts
    wire mr_active = MANUAL_RESET_OE_I && !MANUAL_RESET_N_I;     // [R07]
    wire src_low   = SUPPLY_LOW_I || mr_active;                  // [R01]

    // watchdog edge detect; a floating input is serviced internally
    logic wdi_r;
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            wdi_r <= 1'b0;
        else
            wdi_r <= WATCHDOG_KICK_IN_I;
    end
    wire wd_edge  = WATCHDOG_KICK_OE_I && (wdi_r != WATCHDOG_KICK_IN_I);
    wire wd_off   = !WATCHDOG_KICK_OE_I;                         // [R06]

    supervisor_pkg::rst_state_t st_r;
    supervisor_pkg::rst_state_t st_nxt;
    wire in_reset = (st_r != supervisor_pkg::RST_OFF);
    wire wd_clr   = wd_edge || wd_off || in_reset;               // [R05]
    wire wd_done;
    wire rt_done;

    tick_counter #(.W(CW)) u_wd (
        .clk_i    (SYS_CLK_I),
        .arst_n_i (ARST_N_I),
        .clr_i    (wd_clr),
        .tick_i   (tick),
        .limit_i  (CW'(WD_TICKS)),
        .done_o   (wd_done)
    );

    tick_counter #(.W(CW)) u_rt (
        .clk_i    (SYS_CLK_I),
        .arst_n_i (ARST_N_I),
        .clr_i    (st_r != supervisor_pkg::RST_HOLD),
        .tick_i   (tick),
        .limit_i  (CW'(RST_TICKS)),
        .done_o   (rt_done)
    );

    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            supervisor_pkg::RST_ON:
                if (!src_low)
                    st_nxt = supervisor_pkg::RST_HOLD;             // [R02]
            supervisor_pkg::RST_HOLD:
                if (src_low)
                    st_nxt = supervisor_pkg::RST_ON;
                else if (rt_done)
                    st_nxt = supervisor_pkg::RST_OFF;
            supervisor_pkg::RST_OFF:
                if (src_low)
                    st_nxt = supervisor_pkg::RST_ON;               // [R01]
                else if (wd_done)
                    st_nxt = supervisor_pkg::RST_HOLD;             // [R03] [R04]
            default:
                st_nxt = supervisor_pkg::RST_ON;
        endcase
    end

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            st_r <= supervisor_pkg::RST_ON;
        else
            st_r <= st_nxt;
    end

    // power-fail comparator with hysteresis
    logic pfo_r;
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            pfo_r <= 1'b1;
        else if (PF_BELOW_I)
            pfo_r <= 1'b0;                                       // [R09]
        else if (PF_ABOVE_HYS_I)
            pfo_r <= 1'b1;                                       // [R09]
    end

    // supply switchover; the 1.01 ratio gives hysteresis against chatter
    localparam int PW = VW + 8;
    wire [PW-1:0] vcc_scaled  = PW'(SUPPLY_LEVEL_I) * PW'(`RATIO_DEN);
    wire [PW-1:0] backup_cell_input_scaled = PW'(BACKUP_CELL_INPUT_I) * PW'(`RATIO_NUM);
    wire          backup_cell_input_higher = BACKUP_CELL_INPUT_I > SUPPLY_LEVEL_I;
    wire          vcc_back    = vcc_scaled > backup_cell_input_scaled;          // [R12]
    logic         backup_cell_input_r;
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            backup_cell_input_r <= 1'b0;
        else if (!backup_cell_input_r && in_reset && backup_cell_input_higher)
            backup_cell_input_r <= 1'b1;                                      // [R10]
        else if (backup_cell_input_r && (!in_reset || vcc_back))
            backup_cell_input_r <= 1'b0;                                      // [R11] [R12]
    end

    assign RESET_N_O            = !in_reset;
    assign BACKUP_ACTIVE_FLAG_O = backup_cell_input_r;                        // [R08]
    assign OUT_FROM_BACKUP_CELL_INPUT_O      = backup_cell_input_r;
    assign POWER_FAIL_OUT_N_O   = pfo_r;

    property p_src_resets;
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        src_low |=> !RESET_N_O;
    endproperty
    a_src_resets: assert property (p_src_resets) else $error("reset not low with source"); // [R01]

    property p_hold;
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        (st_r == supervisor_pkg::RST_ON && !src_low) |=> !RESET_N_O [*2];
    endproperty
    a_hold: assert property (p_hold) else $error("reset released without timeout"); // [R02]

    property p_wd_pulse;
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        (RESET_N_O && wd_done && !src_low) |=> !RESET_N_O;
    endproperty
    a_wd_pulse: assert property (p_wd_pulse) else $error("watchdog did not reset"); // [R03]

    property p_wd_low;
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        $fell(RESET_N_O) |-> ($past(src_low) || $past(wd_done));
    endproperty
    a_wd_low: assert property (p_wd_low) else $error("reset without cause"); // [R04]

    property p_wd_clr;
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        wd_clr |=> !wd_done;
    endproperty
    a_wd_clr: assert property (p_wd_clr) else $error("watchdog not cleared"); // [R05]

    property p_wd_off;
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        (wd_off && RESET_N_O && !src_low) |=> RESET_N_O;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("disabled watchdog fired"); // [R06]

    property p_mr_float;
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        (!MANUAL_RESET_OE_I && !SUPPLY_LOW_I && RESET_N_O && !wd_done) |=> RESET_N_O;
    endproperty
    a_mr_float: assert property (p_mr_float) else $error("floating manual reset acted"); // [R07]

    property p_pfo;
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        PF_BELOW_I |=> !POWER_FAIL_OUT_N_O;
    endproperty
    a_pfo: assert property (p_pfo) else $error("power-fail output not low"); // [R09]

    property p_to_backup_cell_input;
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        $rose(OUT_FROM_BACKUP_CELL_INPUT_O) |-> $past(in_reset) && $past(backup_cell_input_higher);
    endproperty
    a_to_backup_cell_input: assert property (p_to_backup_cell_input) else $error("bad switch to battery"); // [R10]

    property p_to_vcc;
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        (OUT_FROM_BACKUP_CELL_INPUT_O && !in_reset) |=> !OUT_FROM_BACKUP_CELL_INPUT_O;
    endproperty
    a_to_vcc: assert property (p_to_vcc) else $error("battery kept out of reset"); // [R11]
endmodule : supervisor_reset_watchdog

// ===== verification/wd_partner.sv
`timescale 1ns/1ps
module wd_partner (
    input  wire logic clk_i,   // processor clock
    input  wire logic run_i,   // processor drives the kick pin
    input  wire logic stall_i, // processor hangs and stops servicing
    output logic      kick_o,  // kick pin level
    output logic      oe_o     // kick driver enabled
);
    logic [2:0] cnt_r  = 3'h0;
    logic       last_r = 1'b0;
    always_ff @(posedge clk_i)
    begin
        cnt_r <= (cnt_r == 3'h5) ? 3'h0 : cnt_r + 3'h1;
        if (run_i && !stall_i && cnt_r == 3'h5)
            last_r <= ~last_r;
    end
    // a released pin floats: a changing pattern keeps a stale level from hiding faults
    assign kick_o = run_i ? last_r : cnt_r[0];
    assign oe_o   = run_i;
endmodule : wd_partner

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0, arst_n = 1'b0, low = 1'b0, mr_n = 1'b1, mr_oe = 1'b1;
    logic        pfb = 1'b0, pfa = 1'b0, run = 1'b0, stall = 1'b0, kick, koe;
    logic [11:0] sup = 12'h0_0c8, bat = 12'h0_000;
    logic        rst_n, flag, pfo_n, obat;
    int          mismatches = 0, tests_run = 0;
    always #12.5 clk = ~clk;
    wd_partner proc (.clk_i(clk), .run_i(run), .stall_i(stall), .kick_o(kick), .oe_o(koe));
    supervisor_reset_watchdog #(.RST_TICKS(4), .WD_TICKS(8), .DIV_CYCLES(2)) dut (
        .SYS_CLK_I(clk), .ARST_N_I(arst_n), .SUPPLY_LOW_I(low), .MANUAL_RESET_N_I(mr_n),
        .MANUAL_RESET_OE_I(mr_oe), .WATCHDOG_KICK_IN_I(kick), .WATCHDOG_KICK_OE_I(koe),
        .PF_BELOW_I(pfb), .PF_ABOVE_HYS_I(pfa), .SUPPLY_LEVEL_I(sup),
        .BACKUP_CELL_INPUT_I(bat), .RESET_N_O(rst_n), .BACKUP_ACTIVE_FLAG_O(flag),
        .POWER_FAIL_OUT_N_O(pfo_n), .OUT_FROM_BACKUP_CELL_INPUT_O(obat));
    task results();
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results
    task check(input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    // reset hold is 4 ticks of 2 clocks, so 5 cycles in it must still show low
    task wait_rst(input logic lvl, input int bound);
        int n;
        n = 0;
        while (rst_n !== lvl && n < bound)
        begin
            step(1);
            n++;
        end
        check(rst_n, lvl);
        // only a real time-out ends the run early, not a level reached on the last step
        if (rst_n !== lvl)
            results();
    endtask : wait_rst
    task t_source(input bit manual);
        @(posedge clk);
        if (manual) mr_n <= 1'b0; else low <= 1'b1;
        step(2);
        check(rst_n, 1'b0);
        @(posedge clk);
        if (manual) mr_n <= 1'b1; else low <= 1'b0;
        step(5);
        check(rst_n, 1'b0);
        wait_rst(1'b1, 30);
    endtask : t_source
    task t_floating_manual();
        @(posedge clk);
        mr_oe <= 1'b0;
        mr_n  <= 1'b0;
        step(30);
        check(rst_n, 1'b1);
        @(posedge clk);
        mr_oe <= 1'b1;
        mr_n  <= 1'b1;
    endtask : t_floating_manual
    task t_watchdog();
        @(posedge clk);
        run <= 1'b1;
        step(60);
        check(rst_n, 1'b1);
        @(posedge clk);
        run <= 1'b0;
        step(60);
        check(rst_n, 1'b1);
        @(posedge clk);
        run   <= 1'b1;
        stall <= 1'b1;
        step(6);
        check(rst_n, 1'b1);
        wait_rst(1'b0, 40);
        @(posedge clk);
        stall <= 1'b0;
        step(5);
        check(rst_n, 1'b0);
        wait_rst(1'b1, 30);
        step(30);
        check(rst_n, 1'b1);
    endtask : t_watchdog
    task t_backup();
        @(posedge clk);
        bat <= 12'h0_064;
        sup <= 12'h0_050;
        low <= 1'b1;
        step(3);
        check({flag, obat}, 2'b11);
        @(posedge clk);
        sup <= 12'h0_065;
        step(3);
        check({flag, obat}, 2'b11);
        @(posedge clk);
        sup <= 12'h0_066;
        step(3);
        check({flag, obat}, 2'b00);
        @(posedge clk);
        sup <= 12'h0_050;
        step(3);
        check({flag, obat}, 2'b11);
        @(posedge clk);
        low <= 1'b0;
        wait_rst(1'b1, 30);
        step(2);
        check({flag, obat}, 2'b00);
    endtask : t_backup
    task t_power_fail();
        @(posedge clk);
        pfb <= 1'b1;
        step(2);
        check(pfo_n, 1'b0);
        @(posedge clk);
        pfb <= 1'b0;
        step(3);
        check(pfo_n, 1'b0);
        @(posedge clk);
        pfa <= 1'b1;
        step(2);
        check(pfo_n, 1'b1);
        // both comparators active: the below-threshold side must win
        @(posedge clk);
        pfb <= 1'b1;
        step(2);
        check(pfo_n, 1'b0);
    endtask : t_power_fail
    initial
    begin
        step(9);
        check({rst_n, flag, pfo_n, obat}, 4'h2);
        @(posedge clk);
        arst_n <= 1'b1;
        step(3);
        check(rst_n, 1'b0);
        wait_rst(1'b1, 40);
        t_source(1'b0);
        t_source(1'b1);
        t_floating_manual();
        t_watchdog();
        t_backup();
        t_power_fail();
        results();
    end
endmodule : tb_top
